// >>> hdl/tpl_position_latch.v
// Touch probe position latch for four axes, two probes per axis.
// Assumes the object port is driven from mclk logic; trigger pins and Z-phase
// and rotation tick signals arrive asynchronously and are synchronised here.
`include "tpl_consts.vh"

module tpl_position_latch (
   input  wire         mclk,
   input  wire         rst_n,
   input  wire [1:0]   obj_axis,
   input  wire [15:0]  obj_index,
   input  wire         obj_wr,
   input  wire [15:0]  obj_wdata,
   output reg  [31:0]  obj_rdata_ff,
   output reg          obj_err_ff,
   input  wire [3:0]   external_latch_input_a,
   input  wire [3:0]   external_latch_input_b,
   input  wire [3:0]   zphase_signal_out,
   input  wire [3:0]   rotation_tick_out,
   input  wire [127:0] feedback_pos,
   input  wire [127:0] command_pos
);

   // Per axis, per probe (index = axis*2 + probe)
   reg [7:0]  func_ff    [0:7];
   reg [7:0]  cap_src_ff [0:7];
   reg [7:0]  trig_sel_ff[0:7];
   reg        rose_ff    [0:7];
   reg        fell_ff    [0:7];
   reg        done_ff    [0:7];
   reg [31:0] pos_rise_ff[0:7];
   reg [31:0] pos_fall_ff[0:7];

   // Three-stage synchronisers: [axis*4 + src], src 0 ext a, 1 ext b, 2 zphase, 3 tick
   reg [15:0] sync1_ff;
   reg [15:0] sync2_ff;
   reg [15:0] sync3_ff;
   reg [15:0] level_ff;
   reg [15:0] prev_ff;

   wire [15:0] raw_in;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_pack
         assign raw_in[g*4+0] = external_latch_input_a[g];
         assign raw_in[g*4+1] = external_latch_input_b[g];
         assign raw_in[g*4+2] = zphase_signal_out[g];
         assign raw_in[g*4+3] = rotation_tick_out[g];
      end
   endgenerate

   // A level counts only once stages two and three agree, rejecting one-cycle glitches
   always @(posedge mclk) begin
      if (!rst_n) begin
         sync1_ff <= 16'h0000;
         sync2_ff <= 16'h0000;
         sync3_ff <= 16'h0000;
         level_ff <= 16'h0000;
         prev_ff  <= 16'h0000;
      end else begin
         sync1_ff <= raw_in;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         level_ff <= (sync2_ff & sync3_ff) | (level_ff & (sync2_ff | sync3_ff));
         prev_ff  <= level_ff;
      end
   end

   function [31:0] pick_pos;
      input [127:0] bus;
      input [1:0]   ax;
      begin
         pick_pos = bus[ax*32 +: 32];
      end
   endfunction

   // Decode which probe an object index names: {hit, probe}; probe field unused if no hit
   function [1:0] probe_of;
      input [15:0] idx;
      input [15:0] a_idx;
      input [15:0] b_idx;
      begin
         probe_of = (idx == a_idx) ? 2'b10 : ((idx == b_idx) ? 2'b11 : 2'b00);
      end
   endfunction

   wire [1:0] hit_cap = probe_of(obj_index, `TPL_IDX_A_CAP_SRC, `TPL_IDX_B_CAP_SRC);
   wire [1:0] hit_sel = probe_of(obj_index, `TPL_IDX_A_TRIG_SEL, `TPL_IDX_B_TRIG_SEL);
   wire [1:0] hit_prs = probe_of(obj_index, `TPL_IDX_POS_A_RISE, `TPL_IDX_POS_B_RISE);
   wire [1:0] hit_pfs = probe_of(obj_index, `TPL_IDX_POS_A_FALL, `TPL_IDX_POS_B_FALL);
   wire       hit_fn  = (obj_index == `TPL_IDX_FUNC);
   wire       hit_st  = (obj_index == `TPL_IDX_STATE);
   wire [2:0] ax_base = {obj_axis, 1'b0};

   wire [2:0] rd_pa   = ax_base;
   wire [2:0] rd_pb   = ax_base + 3'd1;

   // Per-probe working values of the combinational pass below
   integer     p;
   integer     q;
   reg [1:0]   ax;
   reg         pr;
   reg [1:0]   srcsel;
   reg         lvl;
   reg         was;
   reg         armed;
   reg         credit;
   reg         up;
   reg         dn;
   reg         use_cmd;
   reg [31:0]  cap;
   reg         wr_here;
   reg [7:0]   wbyte;
   reg         arm;

   // Next values of the probe registers
   reg [7:0]   nxt_func     [0:7];
   reg [7:0]   nxt_cap_src  [0:7];
   reg [7:0]   nxt_trig_sel [0:7];
   reg         nxt_rose     [0:7];
   reg         nxt_fell     [0:7];
   reg         nxt_done     [0:7];
   reg [31:0]  nxt_pos_rise [0:7];
   reg [31:0]  nxt_pos_fall [0:7];

   // Which of the four synchronised lines of an axis drives one probe
   function [1:0] src_of;
      input internal;
      input tick_sel;
      input probe;
      begin
         if (internal)
            src_of = tick_sel ? 2'd3 : 2'd2;
         else
            src_of = {1'b0, probe};
      end
   endfunction

   // Does a decoded {hit, probe} name this probe
   function names_probe;
      input [1:0] hit;
      input       probe;
      begin
         names_probe = hit[1] && (hit[0] == probe);
      end
   endfunction

   always @* begin
      ax      = 2'd0;
      pr      = 1'b0;
      srcsel  = 2'd0;
      lvl     = 1'b0;
      was     = 1'b0;
      armed   = 1'b0;
      credit  = 1'b0;
      up      = 1'b0;
      dn      = 1'b0;
      use_cmd = 1'b0;
      cap     = 32'h00000000;
      wr_here = 1'b0;
      wbyte   = 8'h00;
      arm     = 1'b0;
      for (p = 0; p < 8; p = p + 1) begin
         nxt_func[p]     = func_ff[p];
         nxt_cap_src[p]  = cap_src_ff[p];
         nxt_trig_sel[p] = trig_sel_ff[p];
         nxt_rose[p]     = rose_ff[p];
         nxt_fell[p]     = fell_ff[p];
         nxt_done[p]     = done_ff[p];
         nxt_pos_rise[p] = pos_rise_ff[p];
         nxt_pos_fall[p] = pos_fall_ff[p];
         ax              = p[2:1];
         pr              = p[0];
         // external input of this probe, or an internal signal
         srcsel = src_of(func_ff[p][`TPL_FN_INTERNAL], trig_sel_ff[p][0], pr);
         lvl    = level_ff[{ax, srcsel}];
         was    = prev_ff[{ax, srcsel}];
         // Both edge flags share one first-trigger credit per arming
         armed  = func_ff[p][`TPL_FN_ENABLE];
         credit = func_ff[p][`TPL_FN_CONTINUOUS] || !done_ff[p];
         up     = armed && credit && func_ff[p][`TPL_FN_RISE_EN] && lvl && !was;
         dn     = armed && credit && func_ff[p][`TPL_FN_FALL_EN] && !lvl && was;
         if (func_ff[p][`TPL_FN_INTERNAL])
            use_cmd = trig_sel_ff[p][0];
         else
            use_cmd = cap_src_ff[p][0];
         cap = use_cmd ? pick_pos(command_pos, ax) : pick_pos(feedback_pos, ax);
         if (up) begin
            nxt_rose[p]     = 1'b1;
            nxt_pos_rise[p] = cap;
            nxt_done[p]     = 1'b1;
         end
         if (dn) begin
            nxt_fell[p]     = 1'b1;
            nxt_pos_fall[p] = cap;
            nxt_done[p]     = 1'b1;
         end
         wr_here = obj_wr && (ax == obj_axis);
         if (wr_here && hit_fn) begin
            wbyte = pr ? obj_wdata[15:8] : obj_wdata[7:0];
            arm   = wbyte[`TPL_FN_ENABLE] && !armed;
            // while enabled only the enable bit may change
            if (armed)
               nxt_func[p] = {func_ff[p][7:1], wbyte[`TPL_FN_ENABLE]};
            else
               nxt_func[p] = wbyte & `TPL_FN_WRITABLE;
            if (arm) begin
               // arming wins over an edge in the same cycle
               nxt_rose[p] = 1'b0;
               nxt_fell[p] = 1'b0;
               nxt_done[p] = 1'b0;
            end
         end
         if (wr_here && names_probe(hit_cap, pr))
            nxt_cap_src[p] = obj_wdata[7:0];
         if (wr_here && names_probe(hit_sel, pr))
            nxt_trig_sel[p] = obj_wdata[7:0];
      end
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         for (q = 0; q < 8; q = q + 1) begin
            func_ff[q]     <= `TPL_FN_BYTE_RST;
            cap_src_ff[q]  <= `TPL_SEL_RST;
            trig_sel_ff[q] <= `TPL_SEL_RST;
            rose_ff[q]     <= 1'b0;
            fell_ff[q]     <= 1'b0;
            done_ff[q]     <= 1'b0;
            pos_rise_ff[q] <= `TPL_POS_RST;
            pos_fall_ff[q] <= `TPL_POS_RST;
         end
      end else begin
         for (q = 0; q < 8; q = q + 1) begin
            func_ff[q]     <= nxt_func[q];
            cap_src_ff[q]  <= nxt_cap_src[q];
            trig_sel_ff[q] <= nxt_trig_sel[q];
            rose_ff[q]     <= nxt_rose[q];
            fell_ff[q]     <= nxt_fell[q];
            done_ff[q]     <= nxt_done[q];
            pos_rise_ff[q] <= nxt_pos_rise[q];
            pos_fall_ff[q] <= nxt_pos_fall[q];
         end
      end
   end

   // Status byte of one probe; bits 3 to 7 always read 0
   function [7:0] state_byte;
      input enabled;
      input rose;
      input fell;
      begin
         state_byte                  = 8'h00;
         state_byte[`TPL_ST_ENABLED] = enabled;
         state_byte[`TPL_ST_ROSE]    = rose;
         state_byte[`TPL_ST_FELL]    = fell;
      end
   endfunction

   // Read answer, registered one cycle after the index is presented
   reg [31:0] nxt_rdata;
   reg        nxt_err;
   always @* begin
      nxt_rdata = 32'h00000000;
      nxt_err   = 1'b0;
      if (hit_fn)
         nxt_rdata = {16'h0000, func_ff[rd_pb], func_ff[rd_pa]};
      else if (hit_st)
         nxt_rdata = {16'h0000, state_byte(func_ff[rd_pb][`TPL_FN_ENABLE], rose_ff[rd_pb], fell_ff[rd_pb]),
                      state_byte(func_ff[rd_pa][`TPL_FN_ENABLE], rose_ff[rd_pa], fell_ff[rd_pa])};
      else if (hit_cap[1])
         nxt_rdata = {24'h000000, cap_src_ff[ax_base + {2'b00, hit_cap[0]}]};
      else if (hit_sel[1])
         nxt_rdata = {24'h000000, trig_sel_ff[ax_base + {2'b00, hit_sel[0]}]};
      else if (hit_prs[1])
         nxt_rdata = pos_rise_ff[ax_base + {2'b00, hit_prs[0]}];
      else if (hit_pfs[1])
         nxt_rdata = pos_fall_ff[ax_base + {2'b00, hit_pfs[0]}];
      else
         nxt_err = 1'b1;
   end

   always @(posedge mclk) begin
      if (!rst_n) begin
         obj_rdata_ff <= 32'h00000000;
         obj_err_ff   <= 1'b0;
      end else begin
         obj_rdata_ff <= nxt_rdata;
         obj_err_ff   <= nxt_err;
      end
   end

endmodule

// >>> hdl/tpl_consts.vh
// Constants of the touch probe position latch: object indices, field bits, reset values.
// Included by the latch module; holds definitions only.
`ifndef TPL_CONSTS_VH
`define TPL_CONSTS_VH

// Object indices
`define TPL_IDX_FUNC        16'h60b8
`define TPL_IDX_STATE       16'h60b9
`define TPL_IDX_POS_A_RISE  16'h60ba
`define TPL_IDX_POS_A_FALL  16'h60bb
`define TPL_IDX_POS_B_RISE  16'h60bc
`define TPL_IDX_POS_B_FALL  16'h60bd
`define TPL_IDX_A_CAP_SRC   16'h44b0
`define TPL_IDX_B_CAP_SRC   16'h44b1
`define TPL_IDX_A_TRIG_SEL  16'h44b2
`define TPL_IDX_B_TRIG_SEL  16'h44b3

// Per-probe byte of the function and state words
`define TPL_PROBE_SHIFT     8
`define TPL_FN_ENABLE       0
`define TPL_FN_CONTINUOUS   1
`define TPL_FN_INTERNAL     2
`define TPL_FN_RISE_EN      4
`define TPL_FN_FALL_EN      5
`define TPL_ST_ENABLED      0
`define TPL_ST_ROSE         1
`define TPL_ST_FELL         2
// Reserved bits 3, 6 and 7 of a function byte are never stored
`define TPL_FN_WRITABLE     8'h37

// Axis count and reset values
`define TPL_AXES            4
`define TPL_AXIS_W          2
`define TPL_FUNC_RST        16'h0000
`define TPL_SEL_RST         8'h00
`define TPL_FN_BYTE_RST     8'h00
`define TPL_POS_RST         32'h00000000

`endif

// >>> dv/tpl_latch_properties.sv
// Checker on the object port of the position latch.
// Assumes one mclk domain and a synchronous active-low rst_n.
module tpl_latch_properties (
   input logic        mclk,
   input logic        rst_n,
   input logic [1:0]  obj_axis,
   input logic [15:0] obj_index,
   input logic        obj_wr,
   input logic [15:0] obj_wdata,
   input logic [31:0] obj_rdata_ff,
   input logic        obj_err_ff
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   logic mapped;
   assign mapped = (obj_index >= 16'h60b8 && obj_index <= 16'h60bd) ||
                   (obj_index >= 16'h44b0 && obj_index <= 16'h44b3);
   a_err_unmapped: assert property (!mapped |=> obj_err_ff) else $error("err missing");
   a_err_mapped: assert property (mapped |=> !obj_err_ff) else $error("err on mapped index");
   a_err_quiet: assert property (obj_err_ff |-> obj_rdata_ff == 32'h0) else $error("data with err");
   a_state_reserved: assert property (obj_index == 16'h60b9 |=>
      obj_rdata_ff[31:11] == 21'h0 && obj_rdata_ff[7:3] == 5'h0) else $error("reserved state bits");
   a_select_byte: assert property (obj_index[15:2] == 14'h112c |=> obj_rdata_ff[31:8] == 24'h0)
      else $error("setting wider than byte");
   a_enable_a: assert property (obj_wr && obj_index == 16'h60b8 ##1
      obj_index == 16'h60b9 && obj_axis == $past(obj_axis) |=> obj_rdata_ff[0] == $past(obj_wdata[0], 2))
      else $error("probe one enable");
   a_enable_b: assert property (obj_wr && obj_index == 16'h60b8 ##1
      obj_index == 16'h60b9 && obj_axis == $past(obj_axis) |=> obj_rdata_ff[8] == $past(obj_wdata[8], 2))
      else $error("probe two enable");
   a_arm_clears: assert property (obj_index == 16'h60b9 ##1 (!obj_rdata_ff[0] && !$past(obj_wr) &&
      obj_wr && obj_index == 16'h60b8 && obj_wdata[0] && obj_axis == $past(obj_axis)) ##1
      (obj_index == 16'h60b9 && $stable(obj_axis)) |=> obj_rdata_ff[2:1] == 2'h0) else $error("flags kept");
endmodule

bind tpl_position_latch tpl_latch_properties chk (.mclk(mclk), .rst_n(rst_n), .obj_axis(obj_axis),
   .obj_index(obj_index), .obj_wr(obj_wr), .obj_wdata(obj_wdata), .obj_rdata_ff(obj_rdata_ff),
   .obj_err_ff(obj_err_ff));

// >>> dv/tpl_trigger_src.sv
// Trigger pins and axis positions seen by the latch.
// Assumes the bench moves them by nonblocking writes at mclk edges.
module tpl_trigger_src (
   output logic [3:0]   ext_a,
   output logic [3:0]   ext_b,
   output logic [3:0]   zph,
   output logic [3:0]   tick,
   output logic [127:0] fb_pos,
   output logic [127:0] cmd_pos
);
   initial begin
      ext_a = 4'h0;
      ext_b = 4'h0;
      zph = 4'h0;
      tick = 4'h0;
      // Distinct per axis so a wrong axis or source shows
      fb_pos = {32'h10000003, 32'h10000002, 32'h10000001, 32'h10000000};
      cmd_pos = {32'h20000003, 32'h20000002, 32'h20000001, 32'h20000000};
   end
endmodule

// >>> dv/tpl_position_latch_tb_top.sv
// Bench for the position latch: object reads and writes plus trigger edges.
// Assumes the checker is bound from its own file.
module tpl_position_latch_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, rst_n = 1'b0, obj_wr = 1'b0;
   logic [1:0] obj_axis = 2'h0;
   logic [15:0] obj_index = 16'h0, obj_wdata = 16'h0;
   logic [31:0] obj_rdata_ff;
   logic obj_err_ff;
   wire [3:0] ea, eb, zp, rt;
   wire [127:0] fb, cm;
   int n_mismatch = 0, compares = 0;
   always #5 mclk = ~mclk;
   tpl_trigger_src drv (.ext_a(ea), .ext_b(eb), .zph(zp), .tick(rt), .fb_pos(fb), .cmd_pos(cm));
   tpl_position_latch uut (.mclk(mclk), .rst_n(rst_n), .obj_axis(obj_axis), .obj_index(obj_index),
      .obj_wr(obj_wr), .obj_wdata(obj_wdata), .obj_rdata_ff(obj_rdata_ff), .obj_err_ff(obj_err_ff),
      .external_latch_input_a(ea), .external_latch_input_b(eb), .zphase_signal_out(zp),
      .rotation_tick_out(rt), .feedback_pos(fb), .command_pos(cm));
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // Parks on the state word so the next cycle shows the write
   task automatic wr(input logic [1:0] ax, input logic [15:0] idx, input logic [15:0] d);
      @(posedge mclk);
      obj_axis <= ax; obj_index <= idx; obj_wdata <= d; obj_wr <= 1'b1;
      @(posedge mclk);
      obj_wr <= 1'b0; obj_index <= 16'h60b9;
   endtask
   // Compares {err, data}; more than one try polls for a trigger to land
   task automatic rd(input logic [1:0] ax, input logic [15:0] idx, input logic [32:0] exp, input int tries = 1);
      int i;
      for (i = 0; i < tries; i++) begin
         @(posedge mclk);
         obj_axis <= ax; obj_index <= idx;
         @(posedge mclk);
         #1;
         if ({obj_err_ff, obj_rdata_ff} === exp) break;
      end
      compares++;
      if ({obj_err_ff, obj_rdata_ff} !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, {obj_err_ff, obj_rdata_ff}, exp);
         if (tries > 1) tally_and_finish;
      end
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      rd(0, 16'h60b9, 33'h0);
      rd(3, 16'h44b3, 33'h0);
      rd(0, 16'h1234, 33'h100000000);
      wr(2, 16'h44b0, 16'h005a);
      rd(2, 16'h44b0, 33'h5a);
      rd(1, 16'h44b0, 33'h0);
      // Probe one on axis 1: external input, command position, both edges, every trigger
      wr(1, 16'h44b0, 16'h0001);
      wr(1, 16'h60b8, 16'h0033);
      @(posedge mclk) drv.ext_a[1] <= 1'b1;
      rd(1, 16'h60b9, 33'h3, 20);
      rd(1, 16'h60ba, 33'h20000001);
      @(posedge mclk) drv.cmd_pos[63:32] <= 32'h20000011;
      drv.ext_a[1] <= 1'b0;
      rd(1, 16'h60b9, 33'h7, 20);
      rd(1, 16'h60bb, 33'h20000011);
      // Probe two on axis 3: tick trigger overrides the feedback choice
      wr(3, 16'h44b3, 16'h0001);
      wr(3, 16'h60b8, 16'h1500);
      @(posedge mclk) drv.ext_b[3] <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(3, 16'h60b9, 33'h100);
      @(posedge mclk) drv.tick[3] <= 1'b1;
      rd(3, 16'h60b9, 33'h300, 20);
      rd(3, 16'h60bc, 33'h20000003);
      // Probe two on axis 2: second external input, falling edge only, feedback position
      wr(2, 16'h60b8, 16'h2100);
      @(posedge mclk) drv.ext_b[2] <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(2, 16'h60b9, 33'h100);
      @(posedge mclk) drv.ext_b[2] <= 1'b0;
      rd(2, 16'h60b9, 33'h500, 20);
      rd(2, 16'h60bd, 33'h10000002);
      // Probe one on axis 0: Z-phase, first trigger only, then rearm
      wr(0, 16'h44b0, 16'h0001);
      wr(0, 16'h60b8, 16'h0015);
      @(posedge mclk) drv.zph[0] <= 1'b1;
      rd(0, 16'h60b9, 33'h3, 20);
      rd(0, 16'h60ba, 33'h10000000);
      @(posedge mclk) drv.fb_pos[31:0] <= 32'h10000020;
      drv.zph[0] <= 1'b0;
      repeat (8) @(posedge mclk);
      drv.zph[0] <= 1'b1;
      repeat (8) @(posedge mclk);
      rd(0, 16'h60ba, 33'h10000000);
      wr(0, 16'h60b8, 16'h0014);
      wr(0, 16'h60b8, 16'h0015);
      rd(0, 16'h60b9, 33'h1);
      wr(0, 16'h60b8, 16'h0035);
      @(posedge mclk) drv.zph[0] <= 1'b0;
      repeat (8) @(posedge mclk);
      rd(0, 16'h60b9, 33'h1);
      tally_and_finish;
   end
endmodule
